// file: lte_top.sv
// touch effect timing block: effect period and group config registers, ten dimmed outputs
// assumes byte register accesses already decoded from the serial config port,
// button states from sensing logic on clk_sys, and an enable bit from global led control
`timescale 1ns/1ps
`default_nettype none
module lte_top #(
	parameter int UNIT_CYC = lte_pkg::LTE_UNIT_CYC
) (
	// clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	// register access
	input  wire logic                         reg_wr_en,
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	output logic      [7:0]                   reg_rdata,
	// effect control
	input  wire logic                         touch_effect_en,
	input  wire logic [lte_pkg::LTE_NUM_OUT-1:0] button_touched,
	// led pins, active low
	output logic      [lte_pkg::LTE_NUM_OUT-1:0] general_output_n
);
	import lte_pkg::*;

	logic [7:0]  effect_period_n_ff [0:3];
	logic [7:0]  group_cfg_ff [0:LTE_NUM_GRP-1];
	logic [31:0] unit_div_ff;
	logic        unit_tick;
	logic [3:0]  pwm_div_ff;
	logic [6:0]  pwm_step_ff;
	logic [LTE_NUM_OUT-1:0] led_on;
	logic [LTE_NUM_OUT-1:0] general_output_n_ff;
	logic [7:0]  grp_period [0:LTE_NUM_GRP-1];

	// output to group map: 0 | 1-3 | 4-6 | 7-9
	function automatic int grp_of(input int idx);
		return (idx + 2) / 3;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				effect_period_n_ff[i] <= LTE_RST_REG;
			end
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				LTE_OFS_PERIOD1: effect_period_n_ff[0] <= reg_wdata;
				LTE_OFS_PERIOD2: effect_period_n_ff[1] <= reg_wdata;
				LTE_OFS_PERIOD3: effect_period_n_ff[2] <= reg_wdata;
				LTE_OFS_PERIOD4: effect_period_n_ff[3] <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int g = 0; g < LTE_NUM_GRP; g++) begin
				group_cfg_ff[g] <= LTE_RST_REG;
			end
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				LTE_OFS_GRP0_CFG: group_cfg_ff[0] <= reg_wdata;
				LTE_OFS_GRP1_CFG: group_cfg_ff[1] <= reg_wdata;
				LTE_OFS_GRP2_CFG: group_cfg_ff[2] <= reg_wdata;
				LTE_OFS_GRP3_CFG: group_cfg_ff[3] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// unmapped offsets, including the second config bytes, read zero
	always_comb begin
		unique case (reg_addr)
			LTE_OFS_PERIOD1:  reg_rdata = effect_period_n_ff[0];
			LTE_OFS_PERIOD2:  reg_rdata = effect_period_n_ff[1];
			LTE_OFS_PERIOD3:  reg_rdata = effect_period_n_ff[2];
			LTE_OFS_PERIOD4:  reg_rdata = effect_period_n_ff[3];
			LTE_OFS_GRP0_CFG: reg_rdata = group_cfg_ff[0];
			LTE_OFS_GRP1_CFG: reg_rdata = group_cfg_ff[1];
			LTE_OFS_GRP2_CFG: reg_rdata = group_cfg_ff[2];
			LTE_OFS_GRP3_CFG: reg_rdata = group_cfg_ff[3];
			default:          reg_rdata = 8'h00;
		endcase
	end

	// 20 ms time base shared by all outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n || unit_div_ff >= 32'(UNIT_CYC - 1)) begin
			unit_div_ff <= 32'h0;
		end else begin
			unit_div_ff <= unit_div_ff + 32'h1;
		end
	end
	assign unit_tick = rst_n && (unit_div_ff >= 32'(UNIT_CYC - 1));

	// pwm sweep: 100 steps, one every LTE_PWM_DIV clocks (100 kHz frame,
	// fast enough to avoid visible flicker, slow enough for led rise times)
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pwm_div_ff  <= 4'h0;
			pwm_step_ff <= 7'h00;
		end else if (pwm_div_ff == 4'(LTE_PWM_DIV - 1)) begin
			pwm_div_ff  <= 4'h0;
			pwm_step_ff <= (pwm_step_ff == LTE_PWM_LAST) ? 7'h00 : pwm_step_ff + 7'h01;
		end else begin
			pwm_div_ff <= pwm_div_ff + 4'h1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < LTE_NUM_GRP; gi++) begin : g_grp
			assign grp_period[gi] =
				effect_period_n_ff[group_cfg_ff[gi][LTE_RU_HI:LTE_RU_LO]];
		end
		for (gi = 0; gi < LTE_NUM_OUT; gi++) begin : g_out
			lte_output_effect u_effect (
				.clk_sys    (clk_sys),
				.rst_n      (rst_n),
				.unit_tick  (unit_tick),
				.pwm_step   (pwm_step_ff),
				.touched    (button_touched[gi]),
				.effect_en  (touch_effect_en),
				.group_cfg  (group_cfg_ff[grp_of(gi)]),
				.ramp_units (grp_period[grp_of(gi)]),
				.led_on     (led_on[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			general_output_n_ff <= '1;
		end else begin
			general_output_n_ff <= ~led_on;
		end
	end
	assign general_output_n = general_output_n_ff;

	AST_UNIT_SPACING: assert property (@(posedge clk_sys) disable iff (!rst_n)
		unit_tick |=> !unit_tick && unit_div_ff == 32'h0)
		else $error("unit tick spacing broken");
	AST_RAMP_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		group_cfg_ff[1][LTE_RU_HI:LTE_RU_LO] == 2'h3 |-> grp_period[1] == effect_period_n_ff[3])
		else $error("ramp select does not pick fourth period");
	AST_GROUP_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr_en && reg_addr == LTE_OFS_GRP3_CFG |=> group_cfg_ff[3] == $past(reg_wdata)
		&& group_cfg_ff[2] == $past(group_cfg_ff[2]))
		else $error("group three config not written");
	AST_PIN_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		led_on[0] |=> !general_output_n[0])
		else $error("active low pin does not follow pwm");

	// pins mirror the pwm compare one cycle late on every output
	AST_PINS_FOLLOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> general_output_n == ~$past(led_on))
		else $error("active low pins lag the pwm compare");

	// fixed-rate sweep: a step lasts exactly LTE_PWM_DIV clocks
	AST_PWM_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pwm_step_ff <= LTE_PWM_LAST)
		else $error("pwm step beyond last step");
	AST_PWM_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pwm_div_ff != 4'(LTE_PWM_DIV - 1) |=> $stable(pwm_step_ff))
		else $error("pwm step moved inside its divider period");
	AST_PWM_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pwm_step_ff == LTE_PWM_LAST && pwm_div_ff == 4'(LTE_PWM_DIV - 1)
		|=> pwm_step_ff == 7'h00)
		else $error("pwm sweep did not wrap to zero");

	// every select code reaches its own period register
	AST_RAMP_SEL_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
		group_cfg_ff[0][LTE_RU_HI:LTE_RU_LO] == 2'h0 |-> grp_period[0] == effect_period_n_ff[0])
		else $error("ramp select does not pick first period");
	AST_RAMP_SEL_SECOND: assert property (@(posedge clk_sys) disable iff (!rst_n)
		group_cfg_ff[0][LTE_RU_HI:LTE_RU_LO] == 2'h1 |-> grp_period[0] == effect_period_n_ff[1])
		else $error("ramp select does not pick second period");
	AST_RAMP_SEL_THIRD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		group_cfg_ff[2][LTE_RU_HI:LTE_RU_LO] == 2'h2 |-> grp_period[2] == effect_period_n_ff[2])
		else $error("ramp select does not pick third period");

	// register map: a write lands in its own register and nowhere else
	sequence s_period2_write;
		reg_wr_en && reg_addr == LTE_OFS_PERIOD2;
	endsequence

	sequence s_grp0_write;
		reg_wr_en && reg_addr == LTE_OFS_GRP0_CFG;
	endsequence

	// the second config byte of group 0 lives outside this block
	sequence s_gap_write;
		reg_wr_en && reg_addr == LTE_OFS_GRP0_CFG + 8'h01;
	endsequence

	AST_PERIOD_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_period2_write |=> effect_period_n_ff[1] == $past(reg_wdata)
		&& effect_period_n_ff[0] == $past(effect_period_n_ff[0]))
		else $error("period two write did not land alone");
	AST_PERIOD4_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr_en && reg_addr == LTE_OFS_PERIOD4 |=> effect_period_n_ff[3] == $past(reg_wdata)
		&& effect_period_n_ff[2] == $past(effect_period_n_ff[2]))
		else $error("period four write did not land alone");
	AST_GROUP0_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_grp0_write |=> group_cfg_ff[0] == $past(reg_wdata)
		&& group_cfg_ff[1] == $past(group_cfg_ff[1]))
		else $error("group zero config not written alone");
	AST_GAP_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_gap_write |=> group_cfg_ff[0] == $past(group_cfg_ff[0])
		&& group_cfg_ff[1] == $past(group_cfg_ff[1]))
		else $error("write to unmapped offset changed a config");
	AST_GAP_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_addr == LTE_OFS_GRP0_CFG + 8'h01 |-> reg_rdata == 8'h00)
		else $error("unmapped offset does not read zero");
endmodule
`default_nettype wire

// file: lte_pkg.sv
// constants for the touch effect timing block: register map, field layout, decode tables
// assumes a single 100 MHz system clock and byte-wide register access
package lte_pkg;
	// register offsets
	localparam logic [7:0] LTE_OFS_PERIOD1  = 8'h02;
	localparam logic [7:0] LTE_OFS_PERIOD2  = 8'h03;
	localparam logic [7:0] LTE_OFS_PERIOD3  = 8'h04;
	localparam logic [7:0] LTE_OFS_PERIOD4  = 8'h05;
	localparam logic [7:0] LTE_OFS_GRP0_CFG = 8'h06;
	localparam logic [7:0] LTE_OFS_GRP1_CFG = 8'h08;
	localparam logic [7:0] LTE_OFS_GRP2_CFG = 8'h0a;
	localparam logic [7:0] LTE_OFS_GRP3_CFG = 8'h0c;
	localparam logic [7:0] LTE_RST_REG      = 8'h00;

	// config field positions
	localparam int LTE_RU_HI   = 7;
	localparam int LTE_RU_LO   = 6;
	localparam int LTE_PK_HI   = 5;
	localparam int LTE_PK_LO   = 3;
	localparam int LTE_REP_HI  = 2;
	localparam int LTE_REP_LO  = 0;

	// timing
	localparam int LTE_CLK_MHZ   = 100;
	localparam int LTE_UNIT_MS   = 20;
	localparam int LTE_UNIT_CYC  = LTE_UNIT_MS * 1000 * LTE_CLK_MHZ;
	localparam int LTE_PWM_STEPS = 100;
	localparam int LTE_PWM_DIV   = 10;
	localparam int LTE_NUM_OUT   = 10;
	localparam int LTE_NUM_GRP   = 4;

	localparam logic [6:0] LTE_FULL_PCT = 7'h64;
	localparam logic [6:0] LTE_PWM_LAST = 7'h63;

	// peak brightness decode, percent
	localparam logic [6:0] LTE_PEAK_PCT [0:7] = '{7'h64, 7'h5a, 7'h50, 7'h41,
		7'h32, 7'h28, 7'h14, 7'h00};
	// repeat count decode
	localparam logic [4:0] LTE_REPEATS [0:7] = '{5'h00, 5'h01, 5'h02, 5'h04,
		5'h06, 5'h0a, 5'h0f, 5'h14};

	typedef enum logic [2:0] {
		LTE_ST_IDLE  = 3'b001,
		LTE_ST_TOUCH = 3'b010,
		LTE_ST_RAMP  = 3'b100
	} lte_state_t;
endpackage

// file: lte_output_effect.sv
// one output's effect engine: touch level, release ramp scenario and pwm compare
// assumes unit_tick every 20 ms and pwm_step sweeping 0..99 on the same clock
`timescale 1ns/1ps
`default_nettype none
module lte_output_effect (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// timing
	input  wire logic       unit_tick,
	input  wire logic [6:0] pwm_step,
	// control
	input  wire logic       touched,
	input  wire logic       effect_en,
	input  wire logic [7:0] group_cfg,
	input  wire logic [7:0] ramp_units,
	// result
	output logic            led_on
);
	import lte_pkg::*;

	lte_state_t  state_ff;
	logic [7:0]  unit_cnt_ff;
	logic [4:0]  rep_cnt_ff;
	logic [6:0]  level_ff;
	logic        led_on_ff;
	logic [6:0]  peak;
	logic [4:0]  repeats;
	logic [14:0] ramp_prod;
	logic [6:0]  ramp_level;

	assign peak    = LTE_PEAK_PCT[group_cfg[LTE_PK_HI:LTE_PK_LO]];
	assign repeats = LTE_REPEATS[group_cfg[LTE_REP_HI:LTE_REP_LO]];
	// widen both factors first so the product cannot wrap at 8 bits
	assign ramp_prod = {8'h00, peak} * {7'h00, unit_cnt_ff};
	// linear ramp, zero length jumps straight to peak
	assign ramp_level = (ramp_units == 8'h00) ? peak :
		7'(ramp_prod / {7'h00, ramp_units});

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff    <= LTE_ST_IDLE;
			unit_cnt_ff <= 8'h00;
			rep_cnt_ff  <= 5'h00;
		end else begin
			unique case (state_ff)
				LTE_ST_IDLE: begin
					if (touched) begin
						state_ff <= LTE_ST_TOUCH;
					end
				end
				LTE_ST_TOUCH: begin
					unit_cnt_ff <= 8'h00;
					rep_cnt_ff  <= 5'h00;
					// disabled config means no scenario at all
					if (!touched) begin
						state_ff <= (effect_en && repeats != 5'h00) ?
							LTE_ST_RAMP : LTE_ST_IDLE;
					end
				end
				LTE_ST_RAMP: begin
					if (touched) begin
						state_ff <= LTE_ST_TOUCH;
					end else if (!effect_en) begin
						state_ff <= LTE_ST_IDLE;
					end else if (unit_cnt_ff >= ramp_units) begin
						unit_cnt_ff <= 8'h00;
						rep_cnt_ff  <= rep_cnt_ff + 5'h01;
						if (rep_cnt_ff + 5'h01 >= repeats) begin
							state_ff <= LTE_ST_IDLE;
						end
					end else if (unit_tick) begin
						unit_cnt_ff <= unit_cnt_ff + 8'h01;
					end
				end
				default: begin
					state_ff <= LTE_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			level_ff <= 7'h00;
		end else if (state_ff == LTE_ST_TOUCH) begin
			level_ff <= effect_en ? peak : LTE_FULL_PCT;
		end else if (state_ff == LTE_ST_RAMP) begin
			level_ff <= ramp_level;
		end else begin
			level_ff <= 7'h00;
		end
	end

	// fixed-rate pwm: on while level exceeds the sweep position
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			led_on_ff <= 1'b0;
		end else begin
			led_on_ff <= (level_ff > pwm_step);
		end
	end
	assign led_on = led_on_ff;

	sequence s_touch_held;
		state_ff == LTE_ST_TOUCH && touched;
	endsequence

	AST_PEAK_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_touch_held ##1 s_touch_held |-> level_ff == $past(effect_en ? peak : LTE_FULL_PCT))
		else $error("touch level does not match peak code");
	AST_REPEAT_END: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_ff == LTE_ST_RAMP && !touched && effect_en && unit_cnt_ff >= ramp_units
		&& rep_cnt_ff + 5'h01 >= repeats |=> state_ff == LTE_ST_IDLE)
		else $error("scenario did not stop after last repeat");
	AST_DISABLED_FULL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_ff == LTE_ST_TOUCH && !touched && !effect_en |=> state_ff == LTE_ST_IDLE)
		else $error("release scenario ran with effects disabled");
	AST_RAMP_RISES: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_ff == LTE_ST_RAMP && $past(state_ff == LTE_ST_RAMP) && unit_cnt_ff > 8'h00
		&& $stable(group_cfg) && $stable(ramp_units) |=> level_ff >= $past(level_ff))
		else $error("ramp level fell during ramp");
endmodule
`default_nettype wire

// file: lte_led_model.sv
// led model: counts the cycles each active-low pin spends lit
// assumes the pins are registered on clk_sys and the bench pulses clr
`timescale 1ns/1ps
`default_nettype none
module lte_led_model (
	// clock
	input  wire logic        clk_sys,
	// control
	input  wire logic        clr,
	// led pins
	input  wire logic [9:0]  general_output_n,
	output logic      [15:0] lit_cnt [0:9]
);
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 10; i++) begin
			if (clr)
				lit_cnt[i] <= 16'h0000;
			else if (general_output_n[i] === 1'b0)
				lit_cnt[i] <= lit_cnt[i] + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// file: lte_top_tb_top.sv
// bench for the touch effect timing block: register tasks and duty measurement
// assumes lte_led_model counts lit cycles; windows are whole pwm frames
`timescale 1ns/1ps
`default_nettype none
module lte_top_tb_top;
	import lte_pkg::*;
	localparam int UNIT = 50;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr_en = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic        touch_effect_en = 1'b1;
	logic [9:0]  button_touched = 10'h000;
	logic [9:0]  general_output_n;
	logic        clr = 1'b0;
	logic [15:0] lit_cnt [0:9];
	logic [15:0] a_cnt;
	int          err_total = 0;
	int          checks_done = 0;
	int          pct [0:7] = '{100, 90, 80, 65, 50, 40, 20, 0};
	int          gpct [0:3] = '{65, 50, 20, 90};
	logic [7:0]  ofs [0:7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h0c};

	always #5 clk_sys = ~clk_sys;

	lte_top #(.UNIT_CYC(UNIT)) u_lte_top (
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.reg_wr_en        (reg_wr_en),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_rdata        (reg_rdata),
		.touch_effect_en  (touch_effect_en),
		.button_touched   (button_touched),
		.general_output_n (general_output_n)
	);

	lte_led_model u_lte_led_model (
		.clk_sys          (clk_sys),
		.clr              (clr),
		.general_output_n (general_output_n),
		.lit_cnt          (lit_cnt)
	);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask

	// strobe is lowered on the closing edge, so back-to-back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk_sys);
		reg_wr_en = 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_addr = a;
		#1;
		chk_reg(reg_rdata, exp, "read data");
	endtask

	task automatic press(input logic [9:0] b, input int settle);
		@(negedge clk_sys);
		button_touched = b;
		repeat (settle) @(negedge clk_sys);
	endtask

	// two whole pwm frames, so the count does not depend on phase
	task automatic measure(input int n);
		@(negedge clk_sys);
		clr = 1'b1;
		@(negedge clk_sys);
		clr = 1'b0;
		repeat (n) @(negedge clk_sys);
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd_chk(ofs[i], 8'h00);
			wr(ofs[i], 8'(8'h11 * (i + 1)));
			rd_chk(ofs[i], 8'(8'h11 * (i + 1)));
		end
		wr(8'h07, 8'hff);
		rd_chk(8'h07, 8'h00);
		for (int i = 0; i < 4; i++)
			wr(ofs[i], 8'h00);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			wr(LTE_OFS_GRP0_CFG, {2'b00, k[2:0], 3'b000});
			press(10'h001, 20);
			measure(2000);
			chk_cnt(lit_cnt[0], 16'(pct[k] * 20), "peak duty");
			press(10'h000, 20);
		end
		$display("test peak levels done");
		wr(LTE_OFS_GRP0_CFG, 8'h18);
		wr(LTE_OFS_GRP1_CFG, 8'he0);
		wr(LTE_OFS_GRP2_CFG, 8'hb0);
		wr(LTE_OFS_GRP3_CFG, 8'h08);
		press(10'h3ff, 20);
		measure(2000);
		for (int i = 0; i < 10; i++)
			chk_cnt(lit_cnt[i], 16'(gpct[(i + 2) / 3] * 20), "group duty");
		press(10'h000, 20);
		$display("test groups done");
		touch_effect_en = 1'b0;
		wr(LTE_OFS_GRP0_CFG, 8'h3f);
		press(10'h001, 20);
		measure(2000);
		chk_cnt(lit_cnt[0], 16'd2000, "disabled touch");
		press(10'h000, 5);
		measure(2000);
		chk_cnt(lit_cnt[0], 16'd0, "disabled release");
		touch_effect_en = 1'b1;
		$display("test disable done");
		wr(LTE_OFS_PERIOD2, 8'h64);
		wr(LTE_OFS_GRP0_CFG, 8'h07);
		press(10'h001, 20);
		press(10'h000, 50);
		measure(2000);
		chk_cnt(lit_cnt[0], 16'd0, "zero period ramp");
		// two repeats of 100 units each: lit inside both, dark after
		wr(LTE_OFS_GRP0_CFG, 8'h42);
		press(10'h001, 20);
		press(10'h000, 0);
		measure(2000);
		a_cnt = lit_cnt[0];
		chk_cnt({15'h0000, a_cnt != 16'd0}, 16'd1, "early ramp lit");
		repeat (500) @(negedge clk_sys);
		measure(2000);
		chk_cnt({15'h0000, lit_cnt[0] > a_cnt}, 16'd1, "ramp rises");
		repeat (1500) @(negedge clk_sys);
		measure(2000);
		chk_cnt({15'h0000, lit_cnt[0] != 16'd0}, 16'd1, "second repeat");
		repeat (3000) @(negedge clk_sys);
		measure(2000);
		chk_cnt(lit_cnt[0], 16'd0, "off after repeats");
		$display("test ramp done");
		wrap_up();
	end
endmodule
`default_nettype wire
